// file: hw/tbpwm_timer.v
// two-channel prescaled modulo timer with compare, capture and pwm, apb slave
// Operation
// - buffer-mode bit links channels 0 and 1 onto the ch0 pin, ch0 first
// - buffered: written compare pair takes over at the next overflow
// - buffered: ch0 control governs output, ch1 control unused, ch1 pin free
// - buffer-mode bit wins over unbuffered-mode bit
// - mode select 0:1 unbuffered, 1:0 buffered compare/pwm
// - edge/level 1:0 clears on compare, 1:1 sets on compare
// - overflow-toggle clear means no overflow toggle, giving 0 percent duty
// - max-duty set with overflow-toggle clear gives 100 percent duty
// - overflow flag set on rollover to zero, interrupt if enabled
// - channel flag set per event, interrupt only when channel enabled
// - wait: timer runs, registers inaccessible, enabled request wakes cpu
// - stop: timer frozen with state kept, resumes on leaving stop
// - break halts counter and suppresses captures
// - break: flags clear only with break-clear enable; pending clears hold
// - overflow flag clears by read-with-flag-set then write 0
// - overflow interrupt enable gates overflow requests, reset clears it
// - halt bit stops counter, set by reset
// - halt bit inhibits captures
// - counter-reset bit clears counter and prescaler, self-clears, reads 0
// - each channel pin is capture or compare, only ch0 has a writable buffer-mode bit
// - prescale select divides by 1 to 64, code 111 invalid
// - modulo high write suppresses overflow flag until low write
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tbpwm_defs.vh"

module tbpwm_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        wait_mode,
  input  wire        stop_mode,
  input  wire        break_active,
  input  wire        break_clear_enable,
  input  wire        ch0_pin_in,
  output wire        ch0_pin_out,
  output wire        ch0_pin_oe,
  input  wire        ch1_pin_in,
  output wire        ch1_pin_out,
  output wire        ch1_pin_oe,
  output wire        overflow_irq,
  output wire        ch0_irq,
  output wire        ch1_irq,
  output wire        timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        setup_ph;
  wire        acc_ph;
  wire        mapped;
  wire        bus_ok;
  wire        wr_acc;
  wire        rd_acc;
  wire        clr_allowed;
  reg         rd_flag_q;

  assign setup_ph = psel & ~penable;
  assign acc_ph   = psel & penable;
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= `TBPWM_OFS_CH1CMP);
  assign bus_ok   = mapped & ~wait_mode;
  assign pready   = 1'b1;
  assign pslverr  = acc_ph & ~bus_ok;
  assign wr_acc   = acc_ph & pwrite & bus_ok;
  assign rd_acc   = acc_ph & ~pwrite & bus_ok;
  assign clr_allowed = ~break_active | break_clear_enable;

  ////////////////////////////////////////////////////////////////////////////
  // status/control and counter

  reg         ovf_q;
  reg         ovie_q;
  reg         halt_q;
  reg  [2:0]  ps_q;
  reg  [15:0] cnt_q;
  reg  [5:0]  presc_q;
  reg  [15:0] mod_q;
  reg         mod_lock_q;
  reg         ovf_arm_q;
  reg  [5:0]  ps_mask;
  wire        run;
  wire        tick;
  wire        ovf_evt;
  wire        crst;

  always @* begin
    case (ps_q)
      3'h0:    ps_mask = 6'h00;
      3'h1:    ps_mask = 6'h01;
      3'h2:    ps_mask = 6'h03;
      3'h3:    ps_mask = 6'h07;
      3'h4:    ps_mask = 6'h0f;
      3'h5:    ps_mask = 6'h1f;
      default: ps_mask = 6'h3f;
    endcase
  end

  assign run  = ~halt_q & ~stop_mode & ~break_active;
  // invalid prescale code never ticks rather than guessing a rate
  assign tick = run && (ps_q != `TBPWM_PS_INVALID) && ((presc_q & ps_mask) == ps_mask);
  assign ovf_evt = tick && (cnt_q == mod_q);
  assign crst = wr_acc && (paddr == `TBPWM_OFS_SC) && pwdata[`TBPWM_SC_CRST];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= `TBPWM_RST_CNT;
      presc_q <= 6'h00;
    end else if (crst) begin
      cnt_q   <= `TBPWM_RST_CNT;
      presc_q <= 6'h00;
    end else if (run) begin
      presc_q <= presc_q + 6'h01;
      if (ovf_evt) begin
        cnt_q <= `TBPWM_RST_CNT;
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovie_q     <= 1'b0;
      halt_q     <= 1'b1;
      ps_q       <= `TBPWM_RST_PS;
      mod_q      <= `TBPWM_RST_MOD;
      mod_lock_q <= 1'b0;
    end else if (wr_acc) begin
      case (paddr)
        `TBPWM_OFS_SC: begin
          ovie_q <= pwdata[`TBPWM_SC_OVIE];
          halt_q <= pwdata[`TBPWM_SC_HALT];
          ps_q   <= pwdata[`TBPWM_SC_PS_HI:`TBPWM_SC_PS_LO];
        end
        `TBPWM_OFS_MODH: begin
          mod_q[15:8] <= pwdata[7:0];
          mod_lock_q  <= 1'b1;
        end
        `TBPWM_OFS_MODL: begin
          mod_q[7:0] <= pwdata[7:0];
          mod_lock_q <= 1'b0;
        end
        default: begin
          mod_lock_q <= mod_lock_q;
        end
      endcase
    end
  end

  // two-step overflow clear, new event voids it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q     <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else if (ovf_evt && !mod_lock_q) begin
      ovf_q     <= 1'b1;
      ovf_arm_q <= 1'b0;
    end else if (rd_acc && (paddr == `TBPWM_OFS_SC) && rd_flag_q && clr_allowed) begin
      ovf_arm_q <= 1'b1;
    end else if (wr_acc && (paddr == `TBPWM_OFS_SC) && clr_allowed) begin
      if (ovf_arm_q && !pwdata[`TBPWM_SC_OVF]) begin
        ovf_q <= 1'b0;
      end
      ovf_arm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffered pair selection

  reg         act_sel_q;
  reg         nxt_sel_q;
  reg         nxt_sel_d;
  wire        buf_mode;
  wire [15:0] cmp0_w;
  wire [15:0] cmp1_w;

  // ch0 buffer bit links the pair
  assign buf_mode = ch[0].sc_q[`TBPWM_CH_BUF];
  assign cmp0_w   = ch[0].cmp_q;
  assign cmp1_w   = ch[1].cmp_q;

  always @* begin
    nxt_sel_d = nxt_sel_q;
    if (wr_acc && (paddr == `TBPWM_OFS_CH0CMP)) begin
      nxt_sel_d = 1'b0;
    end else if (wr_acc && (paddr == `TBPWM_OFS_CH1CMP)) begin
      nxt_sel_d = 1'b1;
    end
  end

  // last written pair wins at overflow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_q <= 1'b0;
      nxt_sel_q <= 1'b0;
    end else if (!buf_mode) begin
      act_sel_q <= 1'b0;
      nxt_sel_q <= 1'b0;
    end else begin
      nxt_sel_q <= nxt_sel_d;
      if (ovf_evt) begin
        act_sel_q <= nxt_sel_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels

  wire [1:0] pin_in;
  wire [1:0] pin_out;
  wire [1:0] pin_oe;
  wire [1:0] ch_flag;
  wire [1:0] ch_ie;

  assign pin_in = {ch1_pin_in, ch0_pin_in};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      reg  [6:0]  sc_q;
      reg  [15:0] cmp_q;
      reg         out_q;
      reg         flag_q;
      reg         arm_q;
      reg         s1_q;
      reg         s2_q;
      reg         s3_q;
      wire [7:0]  sc_ofs;
      wire [7:0]  cmp_ofs;
      wire [1:0]  els;
      wire        idle;
      wire        is_out;
      wire        is_cap;
      wire [15:0] cmp_use;
      wire        match;
      wire        edge_hit;
      wire        cap;
      wire        evt;
      wire        pulse_lvl;

      assign sc_ofs  = (g == 0) ? `TBPWM_OFS_CH0SC : `TBPWM_OFS_CH1SC;
      assign cmp_ofs = (g == 0) ? `TBPWM_OFS_CH0CMP : `TBPWM_OFS_CH1CMP;
      assign els     = sc_q[`TBPWM_CH_ELS_HI:`TBPWM_CH_ELS_LO];
      assign idle    = (g == 1) & buf_mode;
      assign is_out  = sc_q[`TBPWM_CH_UNBUF] | sc_q[`TBPWM_CH_BUF];
      assign is_cap  = ~is_out & (els != `TBPWM_ELS_NONE);
      assign cmp_use = (g == 0 && buf_mode && act_sel_q) ? cmp1_w : cmp_q;
      assign match   = tick && (cnt_q == cmp_use) && is_out && ~idle;
      assign edge_hit = (els[0] & s2_q & ~s3_q) | (els[1] & ~s2_q & s3_q);
      assign cap     = is_cap & ~idle & edge_hit & ~halt_q & ~stop_mode & ~break_active;
      assign evt     = match | cap;
      // pulse level is complement of compare action
      assign pulse_lvl = ~els[0];

      // pin synchroniser; first stage feeds only the second
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sc_q <= 7'h00;
        end else if (wr_acc && (paddr == sc_ofs)) begin
          sc_q <= {pwdata[6], (g == 0) ? pwdata[5] : 1'b0, pwdata[4:0]};
        end
      end

      // capture beats a same-cycle software write
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_q <= 16'h0000;
        end else if (cap) begin
          cmp_q <= cnt_q;
        end else if (wr_acc && (paddr == cmp_ofs)) begin
          cmp_q <= pwdata[15:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q <= 1'b0;
          arm_q  <= 1'b0;
        end else if (evt) begin
          flag_q <= 1'b1;
          arm_q  <= 1'b0;
        end else if (rd_acc && (paddr == sc_ofs) && rd_flag_q && clr_allowed) begin
          arm_q <= 1'b1;
        end else if (wr_acc && (paddr == sc_ofs) && clr_allowed) begin
          if (arm_q && !pwdata[`TBPWM_CH_FLAG]) begin
            flag_q <= 1'b0;
          end
          arm_q <= 1'b0;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_q <= 1'b1;
        end else if (els == `TBPWM_ELS_NONE) begin
          // preset level while the pin belongs to the port
          out_q <= ~sc_q[`TBPWM_CH_UNBUF];
        end else if (is_out && !idle) begin
          if (ovf_evt && sc_q[`TBPWM_CH_MAX]) begin
            // full duty by forcing pulse level
            out_q <= pulse_lvl;
          end else if (match && !sc_q[`TBPWM_CH_MAX]) begin
            case (els)
              `TBPWM_ELS_TOGGLE: out_q <= ~out_q;
              `TBPWM_ELS_CLEAR:  out_q <= 1'b0;
              `TBPWM_ELS_SET:    out_q <= 1'b1;
              default:           out_q <= out_q;
            endcase
          end else if (ovf_evt && sc_q[`TBPWM_CH_TOV]) begin
            out_q <= ~out_q;
          end
        end
      end

      assign pin_out[g] = out_q;
      assign pin_oe[g]  = is_out & ~idle & (els != `TBPWM_ELS_NONE);
      assign ch_flag[g] = flag_q;
      assign ch_ie[g]   = sc_q[`TBPWM_CH_IE];
    end
  endgenerate

  assign ch0_pin_out = pin_out[0];
  assign ch0_pin_oe  = pin_oe[0];
  assign ch1_pin_out = pin_out[1];
  assign ch1_pin_oe  = pin_oe[1];

  ////////////////////////////////////////////////////////////////////////////
  // requests and read data

  assign overflow_irq = ovf_q & ovie_q;
  assign ch0_irq      = ch_flag[0] & ch_ie[0];
  assign ch1_irq      = ch_flag[1] & ch_ie[1];
  // any enabled request wakes the cpu
  assign timer_irq    = overflow_irq | ch0_irq | ch1_irq;

  // read data is sampled in setup so it is stable for the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h00000000;
      rd_flag_q <= 1'b0;
    end else if (setup_ph && !pwrite && mapped && !wait_mode) begin
      rd_flag_q <= 1'b0;
      case (paddr)
        `TBPWM_OFS_SC: begin
          prdata    <= {24'h000000, ovf_q, ovie_q, halt_q, 1'b0, 1'b0, ps_q};
          rd_flag_q <= ovf_q;
        end
        `TBPWM_OFS_CNT:    prdata <= {16'h0000, cnt_q};
        `TBPWM_OFS_MODH:   prdata <= {24'h000000, mod_q[15:8]};
        `TBPWM_OFS_MODL:   prdata <= {24'h000000, mod_q[7:0]};
        `TBPWM_OFS_CH0SC: begin
          prdata    <= {24'h000000, ch_flag[0], ch[0].sc_q};
          rd_flag_q <= ch_flag[0];
        end
        `TBPWM_OFS_CH0CMP: prdata <= {16'h0000, cmp0_w};
        `TBPWM_OFS_CH1SC: begin
          prdata    <= {24'h000000, ch_flag[1], ch[1].sc_q};
          rd_flag_q <= ch_flag[1];
        end
        `TBPWM_OFS_CH1CMP: prdata <= {16'h0000, cmp1_w};
        default:           prdata <= 32'h00000000;
      endcase
    end else if (setup_ph) begin
      prdata    <= 32'h00000000;
      rd_flag_q <= 1'b0;
    end
  end

endmodule // tbpwm_timer

`default_nettype wire

// file: include/tbpwm_defs.vh
// register offsets, field positions, reset values and codes for the pwm timer
`ifndef TBPWM_DEFS_VH
`define TBPWM_DEFS_VH

// byte offsets on the apb bus
`define TBPWM_OFS_SC      8'h00
`define TBPWM_OFS_CNT     8'h04
`define TBPWM_OFS_MODH    8'h08
`define TBPWM_OFS_MODL    8'h0c
`define TBPWM_OFS_CH0SC   8'h10
`define TBPWM_OFS_CH0CMP  8'h14
`define TBPWM_OFS_CH1SC   8'h18
`define TBPWM_OFS_CH1CMP  8'h1c

// timer_status_control fields
`define TBPWM_SC_OVF      7
`define TBPWM_SC_OVIE     6
`define TBPWM_SC_HALT     5
`define TBPWM_SC_CRST     4
`define TBPWM_SC_PS_HI    2
`define TBPWM_SC_PS_LO    0

// channel status_control fields
`define TBPWM_CH_FLAG     7
`define TBPWM_CH_IE       6
`define TBPWM_CH_BUF      5
`define TBPWM_CH_UNBUF    4
`define TBPWM_CH_ELS_HI   3
`define TBPWM_CH_ELS_LO   2
`define TBPWM_CH_TOV      1
`define TBPWM_CH_MAX      0

// edge/level codes
`define TBPWM_ELS_NONE    2'h0
`define TBPWM_ELS_TOGGLE  2'h1
`define TBPWM_ELS_CLEAR   2'h2
`define TBPWM_ELS_SET     2'h3

// prescale codes
`define TBPWM_PS_INVALID  3'h7

// reset values
`define TBPWM_RST_MOD     16'hffff
`define TBPWM_RST_CNT     16'h0000
`define TBPWM_RST_PS      3'h0

`endif

// file: bench/tbpwm_monitor.sv
// port checker for the pwm timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tbpwm_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        wait_mode,
  input wire        stop_mode,
  input wire        break_active,
  input wire        ch0_pin_out,
  input wire        ch1_pin_out,
  input wire        overflow_irq,
  input wire        ch0_irq,
  input wire        ch1_irq,
  input wire        timer_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  reset_quiet_a: assert property ($rose(presetn) |-> !overflow_irq && !ch0_irq && ch0_pin_out)
    else $error("outputs not at reset state");
  wait_err_a: assert property (wait_mode && psel && penable |-> pslverr)
    else $error("access in wait not refused");
  wait_data_a: assert property (wait_mode && psel && !penable |=> prdata == 32'h0)
    else $error("read data returned in wait");
  crst_read_a: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=> !prdata[4])
    else $error("counter reset bit read as one");
  wake_or_a: assert property (timer_irq == (overflow_irq || ch0_irq || ch1_irq))
    else $error("combined request wrong");
  stop_freeze_a: assert property (stop_mode && !psel |=>
    $stable(ch0_pin_out) && $stable(ch1_pin_out) && !$rose(overflow_irq))
    else $error("timer moved in stop");
  break_freeze_a: assert property (break_active && !psel |=>
    $stable(ch0_pin_out) && !$rose(ch0_irq) && !$rose(ch1_irq))
    else $error("timer moved in break");
  ovf_hold_a: assert property (overflow_irq && !(psel && pwrite) |=> overflow_irq)
    else $error("overflow request dropped without a write");
  ch_hold_a: assert property (ch1_irq && !(psel && pwrite) |=> ch1_irq)
    else $error("channel request dropped without a write");
endmodule // tbpwm_monitor
bind tbpwm_timer tbpwm_monitor u_tbpwm_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .wait_mode(wait_mode),
  .stop_mode(stop_mode), .break_active(break_active), .ch0_pin_out(ch0_pin_out),
  .ch1_pin_out(ch1_pin_out), .overflow_irq(overflow_irq), .ch0_irq(ch0_irq),
  .ch1_irq(ch1_irq), .timer_irq(timer_irq)
);
`default_nettype wire

// file: bench/tbpwm_pins.sv
// outside driver model on the two shared channel pins
`timescale 1ns/1ps
`default_nettype none
module tbpwm_pins (
  input  wire ch0_out,
  input  wire ch0_oe,
  input  wire ch1_out,
  input  wire ch1_oe,
  input  wire ext0,
  input  wire ext1,
  output wire ch0_in,
  output wire ch1_in
);
  // port logic drives a pin only while the timer lets go
  assign ch0_in = ch0_oe ? ch0_out : ext0;
  assign ch1_in = ch1_oe ? ch1_out : ext1;
endmodule // tbpwm_pins
`default_nettype wire

// file: bench/tbpwm_tb.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`default_nettype none
`include "tbpwm_defs.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        wait_mode, stop_mode, brk, brk_clr, ext0, ext1, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, d;
  wire  [31:0] prdata;
  wire         pready, pslverr, ch0_in, ch0_out, ch0_oe, ch1_in, ch1_out, ch1_oe;
  wire         overflow_irq, ch0_irq, ch1_irq, timer_irq;
  int          n_fail, comparisons, cyc, h, h2;
  tbpwm_timer u_tbpwm_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(brk),
    .break_clear_enable(brk_clr), .ch0_pin_in(ch0_in), .ch0_pin_out(ch0_out),
    .ch0_pin_oe(ch0_oe), .ch1_pin_in(ch1_in), .ch1_pin_out(ch1_out), .ch1_pin_oe(ch1_oe),
    .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .timer_irq(timer_irq)
  );
  tbpwm_pins u_tbpwm_pins (
    .ch0_out(ch0_out), .ch0_oe(ch0_oe), .ch1_out(ch1_out), .ch1_oe(ch1_oe),
    .ext0(ext0), .ext1(ext1), .ch0_in(ch0_in), .ch1_in(ch1_in)
  );
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chki(input logic v);
    @(negedge pclk);
    chk("overflow request", overflow_irq, v);
  endtask
  task automatic wovf;
    for (int i = 0; i < 300 && overflow_irq !== 1'b1; i++) @(negedge pclk);
  endtask
  task automatic frozen(input string n);
    apb(0, `TBPWM_OFS_CNT, 0);
    h = d;
    apb(0, `TBPWM_OFS_CNT, 0);
    chk(n, d, h);
  endtask
  task automatic meas(input int n);
    h = 0;
    repeat (n) begin
      @(negedge pclk);
      h += (ch0_out === 1'b1);
    end
  endtask
  // halt, reset, period, width, mode, run; never toggle on compare
  task automatic init(input logic [7:0] ctl, input logic [15:0] cmp, input logic [2:0] ps);
    apb(1, `TBPWM_OFS_SC, 32'h30);
    apb(1, `TBPWM_OFS_MODH, 32'h0);
    apb(1, `TBPWM_OFS_MODL, 32'h9);
    apb(1, `TBPWM_OFS_CH0CMP, {16'h0, cmp});
    apb(1, `TBPWM_OFS_CH0SC, {24'h0, ctl});
    apb(1, `TBPWM_OFS_SC, {29'h0, ps});
    meas(10 << ps);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] x [6] = '{32'h20, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      apb(0, a[i], 0);
      chk("reset value", d, x[i]);
    end
    apb(0, 8'h20, 0);
    chk("unmapped error", e, 1);
    apb(1, `TBPWM_OFS_SC, 32'h30);
    apb(0, `TBPWM_OFS_SC, 0);
    chk("counter reset bit", d, 32'h20);
    @(posedge pclk) wait_mode <= 1'b1;
    apb(1, `TBPWM_OFS_MODL, 0);
    chk("wait refusal", e, 1);
    @(posedge pclk) wait_mode <= 1'b0;
    apb(0, `TBPWM_OFS_MODL, 0);
    chk("write in wait", d, 32'hff);
    $display("test reset done");
  endtask
  task automatic t_pwm;
    for (int k = 0; k < 2; k++) begin
      init(k ? 8'h1e : 8'h1a, 16'h2, 3'h0);
      meas(20);
      h2 = h;
      init(k ? 8'h1e : 8'h1a, 16'h6, 3'h0);
      meas(20);
      chk("width step", k ? h2 - h : h - h2, 8);
    end
    chk("pin driven", ch0_oe, 1);
    for (int p = 0; p < 3; p++) begin
      init(8'h1a, 16'h2, p[2:0]);
      meas(20 << p);
      if (p == 0) h2 = h;
      else chk("prescaled width", h, h2 << p);
    end
    init(8'h1a, 16'h2, `TBPWM_PS_INVALID);
    frozen("invalid prescale");
    chk("invalid prescale count", d, 0);
    init(8'h18, 16'h4, 3'h0);
    meas(20);
    chk("zero duty", h, 0);
    init(8'h19, 16'h4, 3'h0);
    meas(20);
    chk("full duty", h, 20);
    apb(0, `TBPWM_OFS_CH0SC, 0);
    chk("channel flag", d[7], 1);
    chk("ch0 request gated", ch0_irq, 0);
    $display("test pwm done");
  endtask
  task automatic t_cap;
    apb(1, `TBPWM_OFS_SC, 32'h20);
    apb(1, `TBPWM_OFS_CH0SC, 0);
    apb(1, `TBPWM_OFS_CH1SC, 32'h44);
    @(posedge pclk) ext1 <= 1'b1;
    repeat (10) @(negedge pclk);
    chk("halted capture", ch1_irq, 0);
    @(posedge pclk) ext1 <= 1'b0;
    apb(1, `TBPWM_OFS_SC, 0);
    repeat (6) @(posedge pclk);
    ext1 <= 1'b1;
    for (int i = 0; i < 10 && ch1_irq !== 1'b1; i++) @(negedge pclk);
    chk("capture request", ch1_irq, 1);
    chk("wake request", timer_irq, 1);
    $display("test capture done");
  endtask
  task automatic t_buf;
    init(8'h3a, 16'h2, 3'h0);
    meas(20);
    h2 = h;
    chk("free pin", ch1_oe, 0);
    apb(1, `TBPWM_OFS_CH1CMP, 32'h6);
    meas(20);
    meas(20);
    chk("buffered switch", h - h2, 8);
    apb(1, `TBPWM_OFS_CH0CMP, 32'h4);
    meas(20);
    meas(20);
    chk("last written pair", h - h2, 4);
    $display("test buffered done");
  endtask
  task automatic t_flags;
    // earlier runs left the overflow flag set; clear it while halted
    apb(1, `TBPWM_OFS_SC, 32'h30);
    apb(0, `TBPWM_OFS_SC, 0);
    apb(1, `TBPWM_OFS_SC, 32'h30);
    apb(1, `TBPWM_OFS_MODH, 0);
    apb(1, `TBPWM_OFS_SC, 0);
    repeat (300) @(posedge pclk);
    apb(0, `TBPWM_OFS_SC, 0);
    chk("held flag", d, 0);
    apb(1, `TBPWM_OFS_MODL, 32'hff);
    repeat (300) @(posedge pclk);
    chki(0);
    apb(1, `TBPWM_OFS_SC, 32'h50);
    chki(1);
    apb(0, `TBPWM_OFS_SC, 0);
    chk("overflow flag", d[7], 1);
    apb(1, `TBPWM_OFS_SC, 32'hc0);
    chki(1);
    apb(0, `TBPWM_OFS_SC, 0);
    apb(1, `TBPWM_OFS_SC, 32'h40);
    chki(0);
    wovf();
    @(posedge pclk) brk <= 1'b1;
    apb(0, `TBPWM_OFS_SC, 0);
    apb(1, `TBPWM_OFS_SC, 32'h40);
    chki(1);
    frozen("break counter");
    @(posedge pclk) brk <= 1'b0;
    apb(0, `TBPWM_OFS_SC, 0);
    @(posedge pclk) brk <= 1'b1;
    apb(1, `TBPWM_OFS_SC, 32'h40);
    chki(1);
    @(posedge pclk) brk <= 1'b0;
    apb(1, `TBPWM_OFS_SC, 32'h40);
    chki(0);
    wovf();
    @(posedge pclk) begin
      brk <= 1'b1;
      brk_clr <= 1'b1;
    end
    apb(0, `TBPWM_OFS_SC, 0);
    apb(1, `TBPWM_OFS_SC, 32'h40);
    @(posedge pclk) brk <= 1'b0;
    chki(0);
    @(posedge pclk) stop_mode <= 1'b1;
    frozen("stop counter");
    @(posedge pclk) stop_mode <= 1'b0;
    apb(0, `TBPWM_OFS_CNT, 0);
    chk("counter resumes", d === h, 0);
    $display("test flags done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // limit sized well above the roughly 3200 cycles the tests take
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    {psel, penable, pwrite, wait_mode, stop_mode, brk, brk_clr, ext0, ext1} = 9'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pwm();
    t_cap();
    t_buf();
    t_flags();
    results();
  end
endmodule // testbench
`default_nettype wire
